// ===== hw/pfci_ctrl.sv
// Contract
// [R1] host pulses write strobe low only while chip select is low
// [R2] device takes address at the later falling strobe
// [R3] device takes data at the earlier rising strobe
// [R4] device idles in low power after a read, wakes without delay
// [R5] no low power after power-up until address moves or select rises
// [R6] device drives data only while select and output gate are low
// [R7] select high deselects the device, bus ignored
// [R8] host must erase the sector before programming a word; the code starts a program without checking that the sector was erased
// [R9] program is three unlock cycles then address and data cycle
// [R10] internal program finishes within ten microseconds
// [R11] during program commands ignored, reads give status only
// [R12] host keeps write-protect constant during program or erase
// [R13] sector erase: six cycles, last one code 30H at sector
// [R14] block erase: six cycles, last one code 50H at block
// [R15] sixth erase cycle: address on fall, code on rise, then erase
// [R16] during erase commands ignored except suspend
// [R17] erase of protected block ignored while write-protect low
// [R18] single cycle B0H suspends erase, read mode within 20 us
// [R19] suspended area reads give status, elsewhere array data
// [R20] while suspended, programs outside suspended area only
// [R21] single cycle 30H at any address resumes the erase
// [R22] poll bit zero during erase, inverted data during program
// [R23] toggle bit alternates while busy, stops when done
// [R24] reset pin low aborts operation, back to array read
// [R25] mismatched sequence cycle abandons the command
// [R26] two setup cycles follow the unlock cycles in erase; the code sends one setup cycle (3CH), then two more unlock cycles
module pfci_ctrl
  import pfci_pkg::*;
#(
  // unlock addresses and codes: arbitrary values
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR_A = 22'h00_0123,
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR_B = 22'h00_0456,
  parameter logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h00a5,
  parameter logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h005a,
  parameter logic [DATA_W-1:0] PROG_SETUP_DATA = 16'h00c3,
  parameter logic [DATA_W-1:0] ERASE_SETUP_DATA = 16'h003c
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_reset_n_out,
  output logic flash_wp_n_out
);
  typedef enum logic [2:0] {S_IDLE, S_SEQ, S_SEQ_WAIT, S_POLL, S_POLL_WAIT,
    S_READ_WAIT, S_RST_LOW, S_RST_REC} pfci_state_t;
  pfci_state_t st;
  logic [2:0] op, idx, last_idx;
  logic [ADDR_W-1:0] target, erase_area;
  logic [DATA_W-1:0] wdata, rdata, dq_meta, dq_sync, cyc_rdata;
  logic erase_blk, erasing, suspended, susp_pend, have_prev, prev_toggle;
  logic done_f, refused_f, timeout_f, wp_cfg;
  logic [11:0] cnt;
  logic cyc_start, cyc_wr, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_data;
  logic ctrl_wr, stat_wr;
  logic [2:0] new_op;
  logic [ADDR_W-1:0] new_addr;

  assign ctrl_wr = reg_write_in && reg_addr_in == REG_CTRL;
  assign stat_wr = reg_write_in && reg_addr_in == REG_STATUS;
  assign new_op = reg_wdata_in[2:0];
  assign new_addr = reg_wdata_in[ADDR_W-1:0];

  function automatic logic same_area(input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] b, input logic blk);
    if (blk)
      same_area = (a >> BLOCK_SHIFT) == (b >> BLOCK_SHIFT);
    else
      same_area = (a >> SECTOR_SHIFT) == (b >> SECTOR_SHIFT);
  endfunction

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] o,
    input logic [2:0] i, input logic [ADDR_W-1:0] t);
    if (o == OP_SUSPEND || o == OP_RESUME)
      seq_addr = t;
    else if (i == 3'h1 || i == 3'h4)
      seq_addr = UNLOCK_ADDR_B;
    else if ((o == OP_PROG && i == PROG_LEN) || i == ERASE_LEN)
      seq_addr = t;
    else
      seq_addr = UNLOCK_ADDR_A;
  endfunction

  function automatic logic [DATA_W-1:0] seq_data(input logic [2:0] o,
    input logic [2:0] i, input logic [DATA_W-1:0] w);
    seq_data = UNLOCK_DATA_A;
    case (i)
      3'h0: begin
        if (o == OP_SUSPEND)
          seq_data = CMD_SUSPEND; // see [R18]
        else if (o == OP_RESUME)
          seq_data = CMD_RESUME; // see [R21]
      end
      3'h1: seq_data = UNLOCK_DATA_B;
      3'h2: seq_data = (o == OP_PROG) ? PROG_SETUP_DATA : ERASE_SETUP_DATA;
      3'h3: seq_data = (o == OP_PROG) ? w : UNLOCK_DATA_A; // see [R9] [R26]
      3'h4: seq_data = UNLOCK_DATA_B; // see [R26]
      3'h5: seq_data = (o == OP_SERASE) ? CMD_SECTOR_ERASE
                                        : CMD_BLOCK_ERASE; // see [R13] [R14]
      default: seq_data = UNLOCK_DATA_A;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else if (clk_en_in) begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
    end
  end

  pfci_cycle u_cycle (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .start_in(cyc_start),
    .write_in(cyc_wr),
    .addr_in(cyc_addr),
    .data_in(cyc_data),
    .dq_sync_in(dq_sync),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .addr_out(flash_addr_out),
    .dq_out(flash_dq_out),
    .dq_oe_out(flash_dq_oe_out),
    .ce_n_out(flash_ce_n_out),
    .we_n_out(flash_we_n_out),
    .oe_n_out(flash_oe_n_out)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st <= S_IDLE;
      op <= CTRL_RESET;
      idx <= 3'h0;
      last_idx <= 3'h0;
      target <= 22'h00_0000;
      erase_area <= 22'h00_0000;
      erase_blk <= 1'b0;
      erasing <= 1'b0;
      suspended <= 1'b0;
      susp_pend <= 1'b0;
      have_prev <= 1'b0;
      prev_toggle <= 1'b0;
      cnt <= 12'h0000;
      rdata <= 16'h0000;
      cyc_start <= 1'b0;
      cyc_wr <= 1'b0;
      cyc_addr <= 22'h00_0000;
      cyc_data <= 16'h0000;
      done_f <= 1'b0;
      refused_f <= 1'b0;
      timeout_f <= 1'b0;
      flash_reset_n_out <= 1'b1;
    end else if (clk_en_in) begin
      cyc_start <= 1'b0;
      // sticky flags: a set in the same cycle wins over the clear
      if (stat_wr && reg_wdata_in[ST_DONE])
        done_f <= 1'b0;
      if (stat_wr && reg_wdata_in[ST_REFUSED])
        refused_f <= 1'b0;
      if (stat_wr && reg_wdata_in[ST_TIMEOUT])
        timeout_f <= 1'b0;
      if (ctrl_wr && new_op == OP_RESET) begin
        st <= S_RST_LOW; // see [R24]
        cnt <= 12'h0000;
        flash_reset_n_out <= 1'b0;
        erasing <= 1'b0;
        suspended <= 1'b0;
        susp_pend <= 1'b0;
      end else if (ctrl_wr && st == S_IDLE) begin
        op <= new_op;
        target <= new_addr;
        idx <= 3'h0;
        if (new_op == OP_READ) begin
          cyc_start <= 1'b1;
          cyc_wr <= 1'b0;
          cyc_addr <= new_addr;
          st <= S_READ_WAIT;
        end else if (new_op == OP_PROG &&
                     !(suspended && same_area(new_addr, erase_area,
                                              erase_blk))) begin
          last_idx <= PROG_LEN; // see [R8] [R20]
          st <= S_SEQ;
        end else if ((new_op == OP_SERASE || new_op == OP_BERASE) &&
                     !erasing) begin
          last_idx <= ERASE_LEN; // see [R15]
          erase_area <= new_addr;
          erase_blk <= new_op == OP_BERASE;
          erasing <= 1'b1;
          st <= S_SEQ;
        end else if (new_op == OP_RESUME && suspended) begin
          last_idx <= 3'h0;
          target <= erase_area;
          suspended <= 1'b0;
          st <= S_SEQ;
        end else
          refused_f <= 1'b1;
      end else if (ctrl_wr && new_op == OP_SUSPEND && erasing &&
                   !suspended && !susp_pend &&
                   (st == S_POLL || st == S_POLL_WAIT) && op != OP_PROG) begin
        susp_pend <= 1'b1; // see [R16]
      end else if (ctrl_wr) begin
        refused_f <= 1'b1; // see [R11] [R16]
      end
      if (!(ctrl_wr && new_op == OP_RESET)) begin
        case (st)
          S_IDLE: cnt <= 12'h0000;
          S_SEQ: begin
            cyc_start <= 1'b1;
            cyc_wr <= 1'b1;
            cyc_addr <= seq_addr(op, idx, target);
            cyc_data <= seq_data(op, idx, wdata);
            st <= S_SEQ_WAIT;
          end
          S_SEQ_WAIT: begin
            if (cyc_done) begin
              idx <= idx + 3'h1;
              st <= (idx == last_idx) ? S_POLL : S_SEQ;
              have_prev <= 1'b0;
              cnt <= 12'h0000;
            end
          end
          S_POLL: begin
            cyc_start <= 1'b1;
            cyc_wr <= 1'b0;
            cyc_addr <= (op == OP_PROG) ? target : erase_area;
            st <= S_POLL_WAIT;
          end
          S_POLL_WAIT: begin
            if (cnt != 12'hfff)
              cnt <= cnt + 12'h0001;
            if (op == OP_PROG && cnt == 12'(PROG_CYC)) begin
              timeout_f <= 1'b1; // see [R10]
              st <= S_IDLE;
            end else if (cyc_done) begin
              have_prev <= 1'b1;
              prev_toggle <= cyc_rdata[TOGGLE_POS];
              if (op == OP_SUSPEND && cnt >= 12'(SUSP_CYC))
                timeout_f <= 1'b1;
              if (susp_pend) begin
                susp_pend <= 1'b0;
                op <= OP_SUSPEND;
                target <= erase_area;
                idx <= 3'h0;
                last_idx <= 3'h0;
                st <= S_SEQ;
              end else if (have_prev &&
                           prev_toggle == cyc_rdata[TOGGLE_POS]) begin
                // toggle has stopped: operation over
                st <= S_IDLE;
                done_f <= 1'b1;
                if (op == OP_SUSPEND)
                  suspended <= 1'b1;
                else if (op != OP_PROG)
                  erasing <= 1'b0;
              end else
                st <= S_POLL;
            end
          end
          S_READ_WAIT: begin
            if (cyc_done) begin
              rdata <= cyc_rdata;
              done_f <= 1'b1;
              st <= S_IDLE;
            end
          end
          S_RST_LOW: begin
            cnt <= cnt + 12'h0001;
            if (cnt == 12'(RST_PULSE_CYC - 1)) begin
              flash_reset_n_out <= 1'b1;
              cnt <= 12'h0000;
              st <= S_RST_REC;
            end
          end
          S_RST_REC: begin
            cnt <= cnt + 12'h0001;
            if (cnt == 12'(RST_REC_CYC - 1)) begin
              done_f <= 1'b1;
              st <= S_IDLE;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wdata <= 16'h0000;
      wp_cfg <= CONFIG_RESET;
      flash_wp_n_out <= CONFIG_RESET;
    end else if (clk_en_in) begin
      if (reg_write_in && reg_addr_in == REG_WDATA)
        wdata <= reg_wdata_in[DATA_W-1:0];
      if (reg_write_in && reg_addr_in == REG_CONFIG)
        wp_cfg <= reg_wdata_in[0];
      if (st == S_IDLE && !erasing)
        flash_wp_n_out <= wp_cfg; // see [R12]
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (clk_en_in) begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_read_in) begin
        case (reg_addr_in)
          REG_CTRL: reg_rdata_out <= {29'h0, op};
          REG_ADDR: reg_rdata_out <= {10'h000, target};
          REG_WDATA: reg_rdata_out <= {16'h0000, wdata};
          REG_STATUS: reg_rdata_out <= {26'h0, timeout_f, refused_f,
            erasing, suspended, done_f, st != S_IDLE};
          REG_RDATA: reg_rdata_out <= {16'h0000, rdata};
          REG_CONFIG: reg_rdata_out <= {31'h0, wp_cfg};
          default: reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  property p_wp_static;
    erasing || st != S_IDLE |=> $stable(flash_wp_n_out);
  endproperty
  a_wp_static: assert property (p_wp_static) else $error("wp moved"); // [R12]
  property p_prog_timeout;
    clk_en_in && st == S_POLL_WAIT && op == OP_PROG &&
      cnt == 12'(PROG_CYC) && !ctrl_wr |=> timeout_f && st == S_IDLE;
  endproperty
  a_prog_timeout: assert property (p_prog_timeout) else $error("no tmo"); // [R10]
  property p_refuse_susp;
    clk_en_in && ctrl_wr && st == S_IDLE && new_op == OP_PROG &&
      suspended && same_area(new_addr, erase_area, erase_blk)
      |=> refused_f && st == S_IDLE;
  endproperty
  a_refuse_susp: assert property (p_refuse_susp) else $error("prog ok"); // [R20]
  property p_rst_pulse;
    $fell(flash_reset_n_out) |-> !flash_reset_n_out[*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("short rst"); // [R24]
  property p_busy_refuse;
    clk_en_in && ctrl_wr && st == S_POLL_WAIT && op == OP_PROG &&
      new_op != OP_RESET |=> refused_f;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("taken"); // [R11]
  sequence s_last_cycle(logic [2:0] o);
    clk_en_in && st == S_SEQ && op == o && idx == ERASE_LEN && !ctrl_wr;
  endsequence
  property p_sector_code;
    s_last_cycle(OP_SERASE) |=> ##1 flash_dq_out == CMD_SECTOR_ERASE;
  endproperty
  a_sector_code: assert property (p_sector_code) else $error("code"); // [R13]
  property p_block_code;
    s_last_cycle(OP_BERASE) |=> ##1 flash_dq_out == CMD_BLOCK_ERASE &&
      flash_addr_out == target;
  endproperty
  a_block_code: assert property (p_block_code) else $error("code"); // [R14]
  property p_prog_word;
    clk_en_in && st == S_SEQ && op == OP_PROG && idx == PROG_LEN &&
      !ctrl_wr |=> ##1 flash_dq_out == wdata && flash_addr_out == target;
  endproperty
  a_prog_word: assert property (p_prog_word) else $error("word"); // [R9]
endmodule

// ===== hw/pfci_pkg.sv
package pfci_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 125;
  // bus cycle times, ns
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_PULSE_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_READ_NS = 100;
  localparam int T_RST_PULSE_NS = 500;
  localparam int T_RST_REC_NS = 500;
  // internal operation limits, us
  localparam int T_PROG_US = 10;
  localparam int T_SUSP_US = 20;
  localparam int SYNC_STAGES = 2;
  // least times round up, longest times round down
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_PULSE_CYC = (T_RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_REC_CYC = (T_RST_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int SUSP_CYC = T_SUSP_US * CLK_MHZ;
  // command codes
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0050;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam int SECTOR_SHIFT = 11;
  localparam int BLOCK_SHIFT = 15;
  localparam int TOGGLE_POS = 6;
  localparam logic [2:0] PROG_LEN = 3'h3;
  localparam logic [2:0] ERASE_LEN = 3'h5;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_SUSP = 2;
  localparam int ST_ERASING = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_TIMEOUT = 5;
  // operations written to the control register
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_SERASE = 3'h3;
  localparam logic [2:0] OP_BERASE = 3'h4;
  localparam logic [2:0] OP_SUSPEND = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic CONFIG_RESET = 1'b1;
endpackage

// ===== hw/pfci_cycle.sv
module pfci_cycle
  import pfci_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] dq_sync_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out
);
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ}
    pfci_cyc_t;
  pfci_cyc_t st;
  logic [11:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st <= C_IDLE;
      cnt <= 12'h0000;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
      addr_out <= 22'h00_0000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      cnt <= cnt + 12'h0001;
      case (st)
        C_IDLE: begin
          cnt <= 12'h0000;
          if (start_in) begin
            addr_out <= addr_in;
            ce_n_out <= 1'b0;
            if (write_in) begin
              dq_out <= data_in;
              dq_oe_out <= 1'b1;
              st <= C_SETUP;
            end else begin
              oe_n_out <= 1'b0;
              st <= C_READ;
            end
          end
        end
        C_SETUP: begin
          if (cnt == 12'(SETUP_CYC - 1)) begin
            // address is taken by the later falling strobe
            we_n_out <= 1'b0; // see [R1] see [R2]
            cnt <= 12'h0000;
            st <= C_PULSE;
          end
        end
        C_PULSE: begin
          if (cnt == 12'(PULSE_CYC - 1)) begin
            // data still driven at the first rising strobe
            we_n_out <= 1'b1; // see [R3]
            cnt <= 12'h0000;
            st <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (cnt == 12'(HOLD_CYC - 1)) begin
            ce_n_out <= 1'b1; // see [R7]
            dq_oe_out <= 1'b0;
            done_out <= 1'b1;
            st <= C_IDLE;
          end
        end
        C_READ: begin
          if (cnt == 12'(READ_CYC + SYNC_STAGES - 1)) begin
            rdata_out <= dq_sync_in; // see [R6]
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            done_out <= 1'b1;
            st <= C_IDLE;
          end
        end
        default: st <= C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_we_low;
    !we_n_out && !ce_n_out;
  endsequence
  property p_we_ce;
    !we_n_out |-> !ce_n_out;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("we low without ce"); // [R1]
  property p_pulse;
    $fell(we_n_out) |-> s_we_low[*5] ##1 we_n_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad we pulse"); // [R2]
  property p_data_rise;
    $rose(we_n_out) |-> dq_oe_out && !ce_n_out && $stable(dq_out);
  endproperty
  a_data_rise: assert property (p_data_rise) else $error("data lost"); // [R3]
  property p_no_clash;
    dq_oe_out |-> oe_n_out;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus clash"); // [R6]
  property p_ce_idle;
    (st == C_IDLE && !start_in) |=> ce_n_out && we_n_out && oe_n_out;
  endproperty
  a_ce_idle: assert property (p_ce_idle) else $error("not deselected"); // [R7]
endmodule

// ===== verif/pfci_flash_model.sv
module pfci_flash_model
  import pfci_pkg::*;
#(
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 30000
) (
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic reset_n_in,
  input wire logic wp_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] AA = 22'h00_0123;
  localparam logic [ADDR_W-1:0] AB = 22'h00_0456;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rd = 16'h0000;
  logic [ADDR_W-1:0] la, ea;
  int seq, pleft, eleft;
  bit er, prog, erase, susp, blk, tog, tog2;
  function automatic bit in_susp(input logic [ADDR_W-1:0] a);
    return blk ? a[21:15] == ea[21:15] : a[21:11] == ea[21:11];
  endfunction
  ////////////////////////////////////////
  always @(negedge we_n_in) if (!ce_n_in) la = addr_in;
  always @(posedge we_n_in) begin
    if (!ce_n_in && reset_n_in) begin
      if (prog || erase && !susp) begin
        if (erase && !prog && dq_in == CMD_SUSPEND) susp = 1;
        seq = 0;
      end else if (susp && seq == 0 && dq_in == CMD_RESUME) begin
        susp = 0;
      end else if (seq == 3 && !er) begin
        if (!(susp && in_susp(la))) begin
          mem[la] = dq_in;
          prog = 1;
          pleft = PROG_NS;
        end
        seq = 0;
      end else if (seq == 5) begin
        if (dq_in inside {CMD_SECTOR_ERASE, CMD_BLOCK_ERASE} &&
            (wp_n_in || la[21:15] != 0)) begin
          erase = 1;
          blk = dq_in[6];
          ea = la;
          eleft = ERASE_NS;
        end
        seq = 0;
      end else if (seq == 2 && la == AA &&
          dq_in inside {16'h00c3, 16'h003c}) begin
        er = dq_in[3];
        seq = 3;
      end else if (seq != 2 && la == (seq % 3 == 1 ? AB : AA) &&
          dq_in == (seq % 3 == 1 ? 16'h005a : 16'h00a5)) begin
        seq++;
      end else begin
        seq = 0;
      end
    end
  end
  always #100 begin
    if (pleft > 0) pleft -= 100;
    else prog = 0;
    if (eleft > 0 && !susp) eleft -= 100;
    else if (!susp) erase = 0;
  end
  always @(negedge reset_n_in) begin
    {prog, erase, susp} = 0;
    {seq, pleft, eleft} = 0;
  end
  // select, gate and address move on one edge: look once they have settled
  always @(negedge oe_n_in) #1 if (!ce_n_in) begin
    tog = ~tog;
    tog2 = ~tog2;
    if (prog) rd = {8'h00, ~mem[la][7], tog, 6'h00};
    else if (erase && (!susp || in_susp(addr_in)))
      rd = {8'h00, susp, susp | tog, 3'h0, tog2, 2'h0};
    else rd = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
  end
  // released bus shows the inverse, never a stale value
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
endmodule

// ===== verif/pfci_ctrl_bench.sv
module pfci_ctrl_bench
  import pfci_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] o; logic [21:0] a; logic [15:0] d;} pfci_row_t;
  logic clock_in = 0, reset_in = 1, reg_write_in = 0, reg_read_in = 0, en = 1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, s;
  logic [DATA_W-1:0] dq_to, dq_from;
  logic ce_n, we_n, oe_n, rst_n, wp_n, dq_oe;
  logic [ADDR_W-1:0] fa;
  logic [2:0] bad [3] = '{3'h0, OP_SUSPEND, OP_RESUME};
  pfci_row_t rows [3] = '{'{OP_PROG, 22'h00_0012, 16'h1234},
    '{OP_PROG, 22'h00_2a0a, 16'hbeef}, '{OP_READ, 22'h00_0401, 16'hffff}};
  int miscompares = 0, cmp_count = 0, rst_low = 0, polls;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
  always #4 clock_in = ~clock_in;
  always @(negedge rst_n) rst_low++;
  pfci_ctrl dut (.clock_in, .reset_in, .clk_en_in(en), .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .flash_dq_in(dq_from), .flash_dq_out(dq_to), .flash_dq_oe_out(dq_oe),
    .flash_addr_out(fa), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_reset_n_out(rst_n),
    .flash_wp_n_out(wp_n));
  pfci_flash_model partner (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .reset_n_in(rst_n), .wp_n_in(wp_n), .addr_in(fa), .dq_in(dq_to),
    .dq_out(dq_from));
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1;
    @(posedge clock_in);
    reg_write_in <= 0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_read_in <= 1;
    @(posedge clock_in);
    reg_read_in <= 0;
    #1 d = reg_rdata_out;
    @(posedge clock_in);
  endtask
  // address low bits equal the op code, so both address paths agree
  task automatic op(input logic [2:0] o, input logic [21:0] a);
    wr(REG_ADDR, 32'(a));
    wr(REG_CTRL, {10'h000, a[21:3], o});
  endtask
  task automatic idle();
    polls = 0;
    do begin
      rd(REG_STATUS, s);
      polls++;
    end while (s[ST_BUSY] !== 1'b0 && polls < 9000);
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clock_in);
    reset_in <= 0;
    `CHK("pins", 6'h3e, {ce_n, we_n, oe_n, rst_n, wp_n, dq_oe})
    rd(8'h40, s);
    `CHK("unmapped", 32'h0000_0000, s)
    rd(REG_CONFIG, s);
    `CHK("config", 32'h0000_0001, s)
    en <= 0;
    wr(REG_CONFIG, 32'h0000_0000);
    en <= 1;
    rd(REG_CONFIG, s);
    `CHK("frozen", 32'h0000_0001, s)
    foreach (rows[i]) begin
      wr(REG_WDATA, 32'(rows[i].d));
      op(rows[i].o, rows[i].a);
      idle();
      `CHK("done", 1'b1, s[ST_DONE])
      rd(REG_RDATA, s);
      // the last-read register only follows reads: a program is seen in the model's memory
      if (rows[i].o == OP_PROG) s[15:0] = partner.mem[rows[i].a];
      `CHK("rdata", rows[i].d, s[15:0])
      wr(REG_STATUS, 32'h0000_003f);
    end
    foreach (bad[i]) begin
      op(bad[i], {19'h0_0000, bad[i]});
      rd(REG_STATUS, s);
      `CHK("refused", 1'b1, s[ST_REFUSED])
      wr(REG_STATUS, 32'h0000_003f);
    end
    op(OP_SERASE, 22'h00_0803);
    repeat (200) @(posedge clock_in);
    op(OP_SUSPEND, 22'h00_0805);
    idle();
    `CHK("susp", 1'b1, s[ST_SUSP])
    op(OP_READ, 22'h00_0801);
    idle();
    rd(REG_RDATA, s);
    `CHK("susp_rd", 2'b11, s[7:6])
    wr(REG_WDATA, 32'h0000_5a5a);
    op(OP_PROG, 22'h00_4002);
    idle();
    `CHK("prog_out", 16'h5a5a, partner.mem[22'h00_4002])
    op(OP_PROG, 22'h00_0802);
    rd(REG_STATUS, s);
    `CHK("prog_in", 1'b1, s[ST_REFUSED])
    op(OP_RESUME, 22'h00_0806);
    idle();
    `CHK("resumed", 2'b00, {s[ST_SUSP], partner.erase})
    wr(REG_CONFIG, 32'h0000_0000);
    op(OP_BERASE, 22'h00_0004);
    idle();
    `CHK("wp_pin", 1'b0, wp_n)
    `CHK("wp_polls", 1'b1, polls < 100)
    wr(REG_CONFIG, 32'h0000_0001);
    op(OP_SERASE, 22'h00_1003);
    repeat (200) @(posedge clock_in);
    op(OP_RESET, 22'h00_0007);
    idle();
    `CHK("hw_reset", 3'b100, {rst_low > 0, partner.erase,
      s[ST_ERASING]})
    wrap_up();
  end
endmodule
